// file: common/dis_pkg.sv
package dis_pkg;

    // Controller clock rate.
    localparam int CLK_MHZ = 100;

    // Bus spacing that follows every command on the memory pins.
    localparam int CMD_GAP_NS = 60;
    localparam int CMD_GAP_CYCLES = (CMD_GAP_NS * CLK_MHZ + 999) / 1000;

    // Quiet time after entering initialization before access completes.
    localparam int SETTLE_NS = 200;
    localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;

    // Register byte offsets.
    localparam int WB_ADR_W = 8;
    localparam logic [7:0] OFS_CONFIG = 8'h70;
    localparam logic [7:0] OFS_STATUS = 8'h74;
    localparam logic [7:0] OFS_INIT_CTRL = 8'h7C;

    // Field positions of the initialization control register.
    localparam int BIT_INIT = 31;
    localparam int BIT_CTRL = 30;
    localparam int BIT_ZQ = 29;
    localparam int BIT_CKE = 28;
    localparam int BIT_RST = 27;
    localparam int BIT_MRS = 26;
    localparam int BIT_REF = 25;
    localparam int BIT_PCHG = 24;
    localparam int CS_LSB = 20;
    localparam int CS_W = 3;
    localparam int BANK_LSB = 16;
    localparam int BANK_W = 3;
    localparam int ADDR_LSB = 0;
    localparam int MEM_ADDR_W = 16;

    // Field positions of the configuration and status registers.
    localparam int CFG_DDR3 = 0;
    localparam int CFG_UNBUF = 1;
    localparam int CFG_PAIR_LSB = 4;
    localparam int PAIR_W = 2;
    localparam int STS_DONE = 0;
    localparam int STS_BUSY = 1;

    localparam int NUM_CS = 8;
    localparam int NUM_KIND = 5;
    localparam int AP_BIT = 10;

    // Command encodings as {ras_n, cas_n, we_n}.
    localparam logic [2:0] RCW_MRS = 3'h0;
    localparam logic [2:0] RCW_REF = 3'h1;
    localparam logic [2:0] RCW_PCHG = 3'h2;
    localparam logic [2:0] RCW_ZQ = 3'h6;
    localparam logic [2:0] RCW_NOP = 3'h7;

    typedef enum logic [2:0] {
        K_MRS = 3'h0,
        K_REF = 3'h1,
        K_PCHG = 3'h2,
        K_ZQ = 3'h3,
        K_CTRL = 3'h4
    } dis_kind_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_DRIVE = 2'h1,
        ST_GAP = 2'h3
    } dis_state_e;

endpackage

// file: common/dis_cmd_if.sv
`timescale 1ns/10ps
interface dis_cmd_if;
    logic req;
    dis_pkg::dis_kind_e kind;
    logic [dis_pkg::NUM_CS-1:0] cs_n;
    logic [dis_pkg::BANK_W-1:0] bank;
    logic [dis_pkg::MEM_ADDR_W-1:0] addr;
    logic busy;
    logic done;

    modport launcher (output req, kind, cs_n, bank, addr, input busy, done);
    modport issuer (input req, kind, cs_n, bank, addr, output busy, done);
endinterface

// file: hw/dis_cmd_issuer.sv
`timescale 1ns/10ps
module dis_cmd_issuer (
    input wire logic clock,
    input wire logic resetn,
    dis_cmd_if.issuer cmd,
    output logic [dis_pkg::NUM_CS-1:0] mem_cs_n,
    output logic mem_ras_n,
    output logic mem_cas_n,
    output logic mem_we_n,
    output logic [dis_pkg::BANK_W-1:0] mem_bank,
    output logic [dis_pkg::MEM_ADDR_W-1:0] mem_addr
);

    localparam int GAP_HI = dis_pkg::CMD_GAP_CYCLES + 1;

    typedef struct packed {
        dis_pkg::dis_state_e state;
        logic [7:0] gap;
        logic done;
        logic [dis_pkg::NUM_CS-1:0] cs_n;
        logic [2:0] rcw;
        logic [dis_pkg::BANK_W-1:0] bank;
        logic [dis_pkg::MEM_ADDR_W-1:0] addr;
    } dis_iss_s;

    dis_iss_s st;
    dis_iss_s next_st;

    // A command owns the pins for one cycle, then NOPs hold the gap.
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        case (st.state)
            dis_pkg::ST_IDLE: begin
                if (cmd.req) begin
                    next_st.state = dis_pkg::ST_DRIVE;
                    next_st.cs_n = cmd.cs_n;
                    next_st.bank = cmd.bank;
                    next_st.addr = cmd.addr;
                    case (cmd.kind)
                        dis_pkg::K_REF: next_st.rcw = dis_pkg::RCW_REF;
                        dis_pkg::K_PCHG: begin
                            next_st.rcw = dis_pkg::RCW_PCHG;
                            next_st.addr[dis_pkg::AP_BIT] = 1'b1; // see RQ13
                        end
                        dis_pkg::K_ZQ: begin
                            next_st.rcw = dis_pkg::RCW_ZQ; // see RQ8
                            next_st.addr[dis_pkg::AP_BIT] = 1'b1;
                        end
                        default: next_st.rcw = dis_pkg::RCW_MRS;
                    endcase
                end
            end
            dis_pkg::ST_DRIVE: begin
                next_st.state = dis_pkg::ST_GAP;
                next_st.gap = 8'(dis_pkg::CMD_GAP_CYCLES - 1);
                next_st.cs_n = '1;
                next_st.rcw = dis_pkg::RCW_NOP;
            end
            dis_pkg::ST_GAP: begin
                if (st.gap == 8'h00) begin
                    next_st.state = dis_pkg::ST_IDLE;
                    next_st.done = 1'b1; // see RQ19
                end else begin
                    next_st.gap = st.gap - 8'h01;
                end
            end
            default: next_st.state = dis_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st <= '0;
            st.state <= dis_pkg::ST_IDLE;
            st.cs_n <= '1;
            st.rcw <= dis_pkg::RCW_NOP;
        end else begin
            st <= next_st;
        end
    end

    assign cmd.busy = (st.state != dis_pkg::ST_IDLE);
    assign cmd.done = st.done;
    assign mem_cs_n = st.cs_n;
    assign {mem_ras_n, mem_cas_n, mem_we_n} = st.rcw;
    assign mem_bank = st.bank;
    assign mem_addr = st.addr;

    property p_done_after_gap;
        @(posedge clock) disable iff (!resetn)
        $rose(cmd.busy) |-> ##[GAP_HI:GAP_HI] cmd.done;
    endproperty
    a_done_after_gap: assert property (p_done_after_gap) // see RQ19
        else $error("command completion not at expected cycle");

    property p_one_cycle_cmd;
        @(posedge clock) disable iff (!resetn)
        (mem_cs_n != '1) |=> (mem_cs_n == '1) [*2];
    endproperty
    a_one_cycle_cmd: assert property (p_one_cycle_cmd) // see RQ12
        else $error("command held on pins longer than one cycle");

endmodule

// file: hw/dis_init_sequencer.sv
// Summary of operation
// RQ1 - Setting init enable enters init mode, holds memory reset, drops CKE.
// RQ2 - Software waits for access complete before raising CKE or reset.
// RQ3 - Software runs the full standard init sequence for its module type.
// RQ4 - Software clears init enable when the sequence is finished.
// RQ5 - Link stop should stay deasserted while init enable is set.
// RQ6 - Software sets at most one command bit per write.
// RQ7 - Control-word bit sends a word to the chosen pair; DDR3 registered.
// RQ8 - ZQ bit issues ZQ calibration, self-clears, valid only in DDR3.
// RQ9 - CKE-raise bit drives CKE high; clearing it never lowers CKE.
// RQ10 - Reset-release bit releases memory reset; clearing never reasserts.
// RQ11 - Mode-register bit issues MRS with programmed address and bank.
// RQ12 - Refresh bit issues one auto refresh, then self-clears.
// RQ13 - Precharge-all bit issues precharge-all, then self-clears.
// RQ14 - Unbuffered: CS field used only outside init; else all selects.
// RQ15 - Registered DDR3: CS field used only during software init.
// RQ16 - CS field is a binary index, 000b to chip select 0 up to 7.
// RQ17 - Mode register commands drive the register bank value on the pins.
// RQ18 - Mode register commands drive the 16-bit address value on pins.
// RQ19 - Command bits read one while pending, clear on completion.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/10ps
module dis_init_sequencer (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [dis_pkg::WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic mem_reset_n,
    output logic mem_cke,
    output logic [dis_pkg::NUM_CS-1:0] mem_cs_n,
    output logic mem_ras_n,
    output logic mem_cas_n,
    output logic mem_we_n,
    output logic [dis_pkg::BANK_W-1:0] mem_bank,
    output logic [dis_pkg::MEM_ADDR_W-1:0] mem_addr
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic init;
        logic keep_cke;
        logic keep_rst;
        logic [dis_pkg::NUM_KIND-1:0] pend;
        logic [dis_pkg::CS_W-1:0] cs_sel;
        logic [dis_pkg::BANK_W-1:0] bank;
        logic [dis_pkg::MEM_ADDR_W-1:0] addr;
        logic ddr3;
        logic unbuf;
        logic [dis_pkg::PAIR_W-1:0] pair;
        logic req;
        logic inflight;
        dis_pkg::dis_kind_e kind;
        logic [dis_pkg::NUM_CS-1:0] cs_n_req;
        logic [7:0] settle;
        logic cke;
        logic rst_n;
    } dis_top_s;

    dis_top_s st;
    dis_top_s next_st;

    dis_cmd_if cmd ();

    // Byte lanes not selected keep their old contents.
    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Active-low select for one chip select given by a binary index.
    function automatic logic [dis_pkg::NUM_CS-1:0] cs_one_hot(
        input logic [dis_pkg::CS_W-1:0] idx);
        return ~(8'h01 << idx); // see RQ16
    endfunction

    // Active-low select for both chip selects of a pair.
    function automatic logic [dis_pkg::NUM_CS-1:0] pair_mask(
        input logic [dis_pkg::PAIR_W-1:0] pair);
        return ~(8'h03 << {pair, 1'b0});
    endfunction

    logic [7:0] adr_word;
    logic wr_fire;
    logic wr_init;
    logic wr_cfg;
    logic init_rise;
    logic set_cke;
    logic set_rst;
    logic unbuf_path;
    logic use_field;
    logic access_done;
    logic [31:0] init_word;
    logic [31:0] cfg_word;
    logic [31:0] sts_word;

    assign adr_word = {wb_adr_i[7:2], 2'b00};
    // Writes take effect at the edge on which ack is presented.
    assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && st.ack;
    assign wr_init = wr_fire && (adr_word == dis_pkg::OFS_INIT_CTRL);
    assign wr_cfg = wr_fire && (adr_word == dis_pkg::OFS_CONFIG);
    assign init_rise = wr_init && wb_sel_i[3] && wb_dat_i[dis_pkg::BIT_INIT]
                       && !st.init;
    assign set_cke = wr_init && wb_sel_i[3] && wb_dat_i[dis_pkg::BIT_CKE];
    assign set_rst = wr_init && wb_sel_i[3] && wb_dat_i[dis_pkg::BIT_RST];

    // DDR2 behaves like an unbuffered module for chip select choice.
    assign unbuf_path = !st.ddr3 || st.unbuf;
    assign use_field = unbuf_path ? !st.init : st.init; // see RQ14, RQ15, RQ4

    // Access completes once the settle time is over and no command waits.
    assign access_done = (st.settle == 8'h00) && (st.pend == '0)
                         && !st.inflight; // see RQ2

    always_comb begin
        init_word = '0;
        init_word[dis_pkg::BIT_INIT] = st.init;
        init_word[dis_pkg::BIT_CTRL] = st.pend[dis_pkg::K_CTRL]; // see RQ19
        init_word[dis_pkg::BIT_ZQ] = st.pend[dis_pkg::K_ZQ];
        init_word[dis_pkg::BIT_CKE] = st.keep_cke;
        init_word[dis_pkg::BIT_RST] = st.keep_rst;
        init_word[dis_pkg::BIT_MRS] = st.pend[dis_pkg::K_MRS];
        init_word[dis_pkg::BIT_REF] = st.pend[dis_pkg::K_REF];
        init_word[dis_pkg::BIT_PCHG] = st.pend[dis_pkg::K_PCHG];
        init_word[dis_pkg::CS_LSB +: dis_pkg::CS_W] = st.cs_sel;
        init_word[dis_pkg::BANK_LSB +: dis_pkg::BANK_W] = st.bank;
        init_word[dis_pkg::ADDR_LSB +: dis_pkg::MEM_ADDR_W] = st.addr;
        cfg_word = '0;
        cfg_word[dis_pkg::CFG_DDR3] = st.ddr3;
        cfg_word[dis_pkg::CFG_UNBUF] = st.unbuf;
        cfg_word[dis_pkg::CFG_PAIR_LSB +: dis_pkg::PAIR_W] = st.pair;
        sts_word = '0;
        sts_word[dis_pkg::STS_DONE] = access_done;
        sts_word[dis_pkg::STS_BUSY] = st.inflight;
    end

    always_comb begin
        logic found;
        logic [31:0] m;
        logic [dis_pkg::NUM_KIND-1:0] valid_kind;
        found = 1'b0;
        m = '0;
        valid_kind = '1;
        valid_kind[dis_pkg::K_ZQ] = st.ddr3; // see RQ8
        valid_kind[dis_pkg::K_CTRL] = st.ddr3 && !st.unbuf; // see RQ7
        next_st = st;
        next_st.req = 1'b0;

        // Bus slave: one wait state, unmapped words read zero.
        next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
        if (wb_cyc_i && wb_stb_i && !st.ack) begin
            case (adr_word)
                dis_pkg::OFS_INIT_CTRL: next_st.rdata = init_word;
                dis_pkg::OFS_CONFIG: next_st.rdata = cfg_word;
                dis_pkg::OFS_STATUS: next_st.rdata = sts_word;
                default: next_st.rdata = '0;
            endcase
        end

        if (st.settle != 8'h00) begin
            next_st.settle = st.settle - 8'h01;
        end

        // Completion clears the bit before any new write can set it again.
        if (cmd.done) begin
            next_st.inflight = 1'b0;
            next_st.pend[st.kind] = 1'b0; // see RQ19
        end

        // Fixed priority keeps the outcome defined if several bits are set.
        if (!st.inflight) begin // see RQ6
            for (int i = 0; i < dis_pkg::NUM_KIND; i++) begin
                if (!found && st.pend[i]) begin
                    found = 1'b1;
                    if (valid_kind[i]) begin
                        next_st.req = 1'b1;
                        next_st.inflight = 1'b1;
                        next_st.kind = dis_pkg::dis_kind_e'(3'(i));
                    end else begin
                        // An unsupported command completes without output.
                        next_st.pend[i] = 1'b0; // see RQ7, RQ8
                    end
                end
            end
        end

        case (next_st.kind)
            dis_pkg::K_MRS: begin
                next_st.cs_n_req = use_field ? cs_one_hot(st.cs_sel) : '0;
            end
            dis_pkg::K_CTRL: next_st.cs_n_req = pair_mask(st.pair); // see RQ7
            default: next_st.cs_n_req = '0;
        endcase
        if (!next_st.req) begin
            next_st.cs_n_req = st.cs_n_req;
        end

        if (wr_init) begin
            m = merge_bytes(init_word, wb_dat_i, wb_sel_i);
            next_st.init = m[dis_pkg::BIT_INIT];
            next_st.keep_cke = m[dis_pkg::BIT_CKE];
            next_st.keep_rst = m[dis_pkg::BIT_RST];
            next_st.cs_sel = m[dis_pkg::CS_LSB +: dis_pkg::CS_W];
            next_st.bank = m[dis_pkg::BANK_LSB +: dis_pkg::BANK_W];
            next_st.addr = m[dis_pkg::ADDR_LSB +: dis_pkg::MEM_ADDR_W];
            if (wb_sel_i[3]) begin
                // Command bits are write-one-to-set; writing zero is ignored.
                if (wb_dat_i[dis_pkg::BIT_CTRL]) begin
                    next_st.pend[dis_pkg::K_CTRL] = 1'b1; // see RQ7
                end
                if (wb_dat_i[dis_pkg::BIT_ZQ]) begin
                    next_st.pend[dis_pkg::K_ZQ] = 1'b1; // see RQ8
                end
                if (wb_dat_i[dis_pkg::BIT_MRS]) begin
                    next_st.pend[dis_pkg::K_MRS] = 1'b1; // see RQ11
                end
                if (wb_dat_i[dis_pkg::BIT_REF]) begin
                    next_st.pend[dis_pkg::K_REF] = 1'b1; // see RQ12
                end
                if (wb_dat_i[dis_pkg::BIT_PCHG]) begin
                    next_st.pend[dis_pkg::K_PCHG] = 1'b1; // see RQ13
                end
            end
        end

        if (wr_cfg) begin
            m = merge_bytes(cfg_word, wb_dat_i, wb_sel_i);
            next_st.ddr3 = m[dis_pkg::CFG_DDR3];
            next_st.unbuf = m[dis_pkg::CFG_UNBUF];
            next_st.pair = m[dis_pkg::CFG_PAIR_LSB +: dis_pkg::PAIR_W];
        end

        // Entering init wins over a CKE or reset release in the same write.
        if (init_rise) begin
            next_st.cke = 1'b0; // see RQ1
            next_st.rst_n = 1'b0;
            next_st.settle = 8'(dis_pkg::SETTLE_CYCLES);
        end else begin
            if (set_cke) begin
                next_st.cke = 1'b1; // see RQ9
            end
            if (set_rst) begin
                next_st.rst_n = 1'b1; // see RQ10
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cmd.req = st.req;
    assign cmd.kind = st.kind;
    assign cmd.cs_n = st.cs_n_req;
    assign cmd.bank = st.bank; // see RQ17
    assign cmd.addr = st.addr; // see RQ18
    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
    assign mem_cke = st.cke;
    assign mem_reset_n = st.rst_n;

    dis_cmd_issuer u_issuer (
        .clock(clock),
        .resetn(resetn),
        .cmd(cmd),
        .mem_cs_n(mem_cs_n),
        .mem_ras_n(mem_ras_n),
        .mem_cas_n(mem_cas_n),
        .mem_we_n(mem_we_n),
        .mem_bank(mem_bank),
        .mem_addr(mem_addr)
    );

    logic on_pins;
    logic mrs_on_pins;
    logic ref_on_pins;
    logic pchg_on_pins;
    logic zq_on_pins;
    assign on_pins = (mem_cs_n != '1);
    assign mrs_on_pins = on_pins && ({mem_ras_n, mem_cas_n, mem_we_n}
                         == dis_pkg::RCW_MRS);
    assign ref_on_pins = on_pins && ({mem_ras_n, mem_cas_n, mem_we_n}
                         == dis_pkg::RCW_REF);
    assign pchg_on_pins = on_pins && ({mem_ras_n, mem_cas_n, mem_we_n}
                          == dis_pkg::RCW_PCHG);
    assign zq_on_pins = on_pins && ({mem_ras_n, mem_cas_n, mem_we_n}
                        == dis_pkg::RCW_ZQ);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    property p_init_enter;
        init_rise |=> !mem_reset_n && !mem_cke && st.init;
    endproperty
    a_init_enter: assert property (p_init_enter) // see RQ1
        else $error("init entry did not hold reset and drop CKE");

    property p_cke_raise;
        set_cke && !init_rise |=> mem_cke;
    endproperty
    a_cke_raise: assert property (p_cke_raise) // see RQ9
        else $error("CKE not raised");

    property p_cke_hold;
        mem_cke && !init_rise |=> mem_cke;
    endproperty
    a_cke_hold: assert property (p_cke_hold) // see RQ9
        else $error("CKE dropped without init entry");

    property p_rst_hold;
        (set_rst || mem_reset_n) && !init_rise |=> mem_reset_n;
    endproperty
    a_rst_hold: assert property (p_rst_hold) // see RQ10
        else $error("memory reset reasserted or not released");

    property p_refresh_issue;
        $rose(st.pend[dis_pkg::K_REF]) |-> ##[1:80] ref_on_pins;
    endproperty
    a_refresh_issue: assert property (p_refresh_issue) // see RQ12
        else $error("auto refresh not issued");

    property p_pchg_a10;
        pchg_on_pins |-> mem_addr[dis_pkg::AP_BIT] && (mem_cs_n == '0);
    endproperty
    a_pchg_a10: assert property (p_pchg_a10) // see RQ13
        else $error("precharge-all without A10 or on partial selects");

    property p_mrs_fields;
        mrs_on_pins && st.kind == dis_pkg::K_MRS
            |-> mem_addr == st.addr && mem_bank == st.bank;
    endproperty
    a_mrs_fields: assert property (p_mrs_fields) // see RQ11, RQ17, RQ18
        else $error("mode register command carries wrong fields");

    property p_mrs_cs;
        mrs_on_pins && st.kind == dis_pkg::K_MRS
            |-> mem_cs_n == (use_field ? cs_one_hot(st.cs_sel) : '0);
    endproperty
    a_mrs_cs: assert property (p_mrs_cs) // see RQ14, RQ15, RQ16
        else $error("mode register command on wrong chip selects");

    property p_ctrl_pair;
        mrs_on_pins && st.kind == dis_pkg::K_CTRL
            |-> mem_cs_n == pair_mask(st.pair) && st.ddr3 && !st.unbuf;
    endproperty
    a_ctrl_pair: assert property (p_ctrl_pair) // see RQ7
        else $error("control word on wrong pair or mode");

    property p_zq_ddr3;
        zq_on_pins |-> st.ddr3;
    endproperty
    a_zq_ddr3: assert property (p_zq_ddr3) // see RQ8
        else $error("ZQ calibration issued outside DDR3 mode");

    property p_mrs_self_clear;
        $fell(st.pend[dis_pkg::K_MRS]) |-> $past(cmd.done);
    endproperty
    a_mrs_self_clear: assert property (p_mrs_self_clear) // see RQ19
        else $error("mode register bit cleared before completion");

    c_mrs: cover property (mrs_on_pins && use_field);
    c_refresh: cover property (ref_on_pins);
    c_zq: cover property (zq_on_pins);
    c_ready: cover property (mem_cke && mem_reset_n && st.init);

endmodule

// file: sim/dis_mem_model.sv
`timescale 1ns/10ps
module dis_mem_model (
    input wire logic clock,
    input wire logic [7:0] cs_n,
    input wire logic [2:0] cmd,
    input wire logic [2:0] bank,
    input wire logic [15:0] addr
);
    int count = 0;
    logic [7:0] last_cs_n = 8'hFF;
    logic [2:0] last_cmd = 3'h7;
    logic [2:0] last_bank = 3'h0;
    logic [15:0] last_addr = 16'h0;
    // No link stop reaches the modules while init runs.
    // Any cycle with a chip select low is one command to the modules.
    always @(posedge clock) begin
        if (cs_n != 8'hFF) begin
            count <= count + 1;
            last_cs_n <= cs_n;
            last_cmd <= cmd;
            last_bank <= bank;
            last_addr <= addr;
        end
    end
endmodule

// file: sim/dis_init_sequencer_bench.sv
`timescale 1ns/10ps
module dis_init_sequencer_bench;
    typedef struct {
        logic [31:0] cfg, ctl;
        logic [2:0] cmd, bank;
        logic [7:0] csn;
        logic [15:0] addr, amask;
    } dis_row_s;
    logic clock = 1'b0;
    logic resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0, rd, dat_o;
    logic ack, rst_n, cke, ras_n, cas_n, we_n;
    logic [7:0] cs_n;
    logic [2:0] bank;
    logic [15:0] addr;
    int n_mismatch = 0, num_checks = 0, c0;
    // One command bit per write.
    dis_row_s rows[8] = '{
        '{32'h3, 32'h8405A5C3, 3'h0, 3'h5, 8'h00, 16'hA5C3, 16'hFFFF},
        '{32'h3, 32'h82000000, 3'h1, 3'h0, 8'h00, 16'h0, 16'h0},
        '{32'h3, 32'h81000000, 3'h2, 3'h0, 8'h00, 16'h0400, 16'h0400},
        '{32'h3, 32'hA0000000, 3'h6, 3'h0, 8'h00, 16'h0400, 16'h0400},
        '{32'h1, 32'h84731234, 3'h0, 3'h3, 8'h7F, 16'h1234, 16'hFFFF},
        '{32'h1, 32'h84060042, 3'h0, 3'h6, 8'hFE, 16'h0042, 16'hFFFF},
        '{32'h11, 32'hC0020055, 3'h0, 3'h2, 8'hF3, 16'h0055, 16'hFFFF},
        '{32'h1, 32'h04731234, 3'h0, 3'h3, 8'h00, 16'h1234, 16'hFFFF}
    };

    dis_init_sequencer DUT (.clock(clock), .resetn(resetn),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .mem_reset_n(rst_n), .mem_cke(cke),
        .mem_cs_n(cs_n), .mem_ras_n(ras_n), .mem_cas_n(cas_n),
        .mem_we_n(we_n), .mem_bank(bank), .mem_addr(addr));
    dis_mem_model mem (.clock(clock), .cs_n(cs_n),
        .cmd({ras_n, cas_n, we_n}), .bank(bank), .addr(addr));

    initial begin
        forever #5 clock = ~clock;
    end

    task report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task give_up(input string s);
        n_mismatch++;
        $display("[FAIL] %s expected done seen timeout", s);
        report_and_stop();
    endtask

    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clock);
            i++;
            if (i > 20)
                give_up("bus");
        end while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        for (int i = 0; i < 40; i++) begin
            wb(1'b0, a, 32'h0);
            if ((rd & m) === v)
                return;
        end
        give_up("poll");
    endtask

    task wait_cmd(input int c);
        for (int i = 0; i < 40; i++) begin
            @(negedge clock);
            if (mem.count != c)
                return;
        end
        give_up("command");
    endtask

    initial begin
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        @(negedge clock);
        chk("cs_n", 32'hFF, cs_n);
        wb(1'b0, 8'h7C, 32'h0);
        chk("init_reg", 32'h0, rd);
        wb(1'b1, 8'h70, 32'h3);
        wb(1'b1, 8'h7C, 32'h80000000);
        @(negedge clock);
        chk("cke", 32'h0, cke);
        chk("reset_n", 32'h0, rst_n);
        poll(8'h74, 32'h1, 32'h1);
        wb(1'b1, 8'h7C, 32'h90000000);
        @(negedge clock);
        chk("cke", 32'h1, cke);
        wb(1'b1, 8'h7C, 32'h88000000);
        wb(1'b1, 8'h7C, 32'h80000000);
        @(negedge clock);
        chk("cke", 32'h1, cke);
        chk("reset_n", 32'h1, rst_n);
        $display("test power_up done");
        foreach (rows[i]) begin
            wb(1'b1, 8'h70, rows[i].cfg);
            c0 = mem.count;
            wb(1'b1, 8'h7C, rows[i].ctl);
            wait_cmd(c0);
            chk("cmd", rows[i].cmd, mem.last_cmd);
            chk("cs_n", rows[i].csn, mem.last_cs_n);
            chk("addr", rows[i].addr, mem.last_addr & rows[i].amask);
            if (rows[i].amask == 16'hFFFF)
                chk("bank", rows[i].bank, mem.last_bank);
            poll(8'h7C, 32'h7F000000, 32'h0);
        end
        $display("test commands done");
        wb(1'b1, 8'h70, 32'h3);
        c0 = mem.count;
        wb(1'b1, 8'h7C, 32'h04335678);
        wb(1'b0, 8'h7C, 32'h0);
        chk("pending", 32'h04000000, rd & 32'h04000000);
        wait_cmd(c0);
        chk("cs_n", 32'hF7, mem.last_cs_n);
        poll(8'h7C, 32'h04000000, 32'h0);
        $display("test init_exit done");
        wb(1'b1, 8'h70, 32'h0);
        c0 = mem.count;
        wb(1'b1, 8'h7C, 32'h20000000);
        poll(8'h7C, 32'h20000000, 32'h0);
        wb(1'b1, 8'h7C, 32'h40000000);
        poll(8'h7C, 32'h40000000, 32'h0);
        chk("no_cmd", c0, mem.count);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        wb(1'b1, 8'h7C, 32'h80000000);
        @(negedge clock);
        chk("cke", 32'h0, cke);
        chk("reset_n", 32'h0, rst_n);
        $display("test refusals done");
        report_and_stop();
    end
endmodule
